// File: logic/cvt_pkg.sv
// Constants and types shared by the coprocessor address translation unit.
package cvt_pkg;
    // Register byte offsets on the AXI4-Lite bus.
    localparam logic [7:0] CVT_OFF_DIR_BASE = 8'h00;
    localparam logic [7:0] CVT_OFF_CUR_VA = 8'h04;
    localparam logic [7:0] CVT_OFF_CTRL = 8'h08;
    localparam logic [7:0] CVT_OFF_STAT = 8'h0C;
    // Control register fields and reset value.
    localparam int CVT_CTRL_ON = 0;
    localparam int CVT_CTRL_PRIV = 2;
    localparam int CVT_CTRL_PV_EN = 6;
    localparam int CVT_CTRL_NP_EN = 7;
    localparam logic [7:0] CVT_CTRL_MASK = 8'hC5;
    localparam logic [7:0] CVT_CTRL_RST = 8'h00;
    // Status register fields.
    localparam int CVT_STAT_PV = 6;
    localparam int CVT_STAT_NP = 7;
    localparam logic [7:0] CVT_STAT_MASK = 8'hC0;
    // Table entry fields.
    localparam int CVT_ENT_P = 0;
    localparam int CVT_ENT_RW = 1;
    localparam int CVT_ENT_US = 2;
    localparam int CVT_ENT_A = 5;
    localparam int CVT_ENT_D = 6;
    // Linear address split and look-aside entries.
    localparam int CVT_DIR_LSB = 22;
    localparam int CVT_TBL_LSB = 12;
    localparam int CVT_TLB_N = 2;
    localparam int CVT_MAP_DST = 1;
    // AXI response codes.
    localparam logic [1:0] CVT_RESP_OKAY = 2'h0;
    localparam logic [1:0] CVT_RESP_SLVERR = 2'h2;
    // Walk states, Gray coded along the usual path.
    typedef enum logic [2:0] {
        CVT_ST_IDLE = 3'h0,
        CVT_ST_PDE_RD = 3'h1,
        CVT_ST_PDE_WB = 3'h3,
        CVT_ST_PTE_RD = 3'h2,
        CVT_ST_PTE_WB = 3'h6,
        CVT_ST_DATA = 3'h7,
        CVT_ST_FAULT = 3'h5
    } cvt_state_t;
endpackage : cvt_pkg

// File: logic/cvt_translate.sv
// Coprocessor virtual address translation unit with two-entry look-aside buffer.
//
// Function
// R1 - Translation off: linear address passes unchanged.
// R2 - One control bit turns translation on.
// R3 - Two-level directory and table walk, 4KB pages.
// R4 - Address split 31:22, 21:12, 11:0.
// R5 - Software loads aligned directory base before use.
// R6 - Directory entry gives page table base.
// R7 - Table entry frame plus offset gives data.
// R8 - Entry: frame 31:12, dirty 6, accessed 5, present 0.
// R9 - Walk sets accessed in both entries.
// R10 - Write walk sets dirty in table entry.
// R11 - Supervisor mode performs no protection checks.
// R12 - User rights follow user and write flags.
// R13 - Rights violation abandons cycle, raises interrupt.
// R14 - Missing entry raises page-not-present interrupt.
// R15 - Other entry bits ignored and never changed.
// R16 - Two entries: source maps and destination map.
// R17 - Entry holds tag, valid, physical frame.
// R18 - Valid tag match forms address from frame.
// R19 - Miss walks from base and fills entry.
// R20 - Writing directory base invalidates entries.
// R21 - Suspending an operation invalidates entries.
// R22 - Writes only for the destination map.
// R23 - Control bit 2 selects supervisor or user.
// R24 - Control bit 0 enables translation.
// R25 - Bits 7, 6 gate interrupts; status always updates.
// R26 - Clearing a fault flag retries the access.
// R27 - Entry fetch is aligned word at base plus index.
//
// Added by the designer: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module cvt_translate
    import cvt_pkg::*;
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic suspend,
    input wire logic cp_valid,
    output logic cp_ready,
    input wire logic [31:0] cp_addr,
    input wire logic cp_write,
    input wire logic cp_dst,
    input wire logic [31:0] cp_wdata,
    output logic cp_done,
    output logic [31:0] cp_rdata,
    output logic mem_req,
    output logic mem_we,
    output logic [31:0] mem_addr,
    output logic [31:0] mem_wdata,
    input wire logic mem_ack,
    input wire logic [31:0] mem_rdata,
    output logic missing_page_irq,
    output logic rights_fault_irq
);
    cvt_state_t st_r, st_nxt;
    logic aw_hold_r, w_hold_r, awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
    logic [7:0] awaddr_r;
    logic [31:0] wdat_r, rdata_r;
    logic [3:0] wstrb_r;
    logic [1:0] bresp_r, rresp_r;
    logic [19:0] base_r, cva_r;
    logic [7:0] ctrl_r, stat_r, stat_nxt;
    logic [31:0] la_r, cwd_r, ent_r, cp_rdata_r;
    logic wr_r, map_r, cp_ready_r, cp_done_r;
    logic mem_req_r, mem_we_r;
    logic [31:0] mem_addr_r, mem_wdata_r;
    logic np_irq_r, pv_irq_r;
    logic [19:0] tag_r [CVT_TLB_N];
    logic [19:0] frame_r [CVT_TLB_N];
    logic [CVT_TLB_N-1:0] val_r;
    logic wr_go, base_wr, flush, accept, wr_eff, user, hit, np, pv, fill;
    logic iss, iss_we;
    logic [31:0] iss_addr, iss_wdata, wmask;
    logic [19:0] fill_frame;

    // Write channel: address and data are caught in either order.
    assign wr_go = aw_hold_r && w_hold_r && !bvalid_r;
    assign wmask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
    assign base_wr = wr_go && awaddr_r == CVT_OFF_DIR_BASE;
    assign flush = base_wr || suspend; // R20 R21

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
            awready_r <= 1'b1;
            wready_r <= 1'b1;
            bvalid_r <= 1'b0;
            bresp_r <= CVT_RESP_OKAY;
            awaddr_r <= 8'h00;
            wdat_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
        end else begin
            if (s_axi_awvalid && awready_r) begin
                aw_hold_r <= 1'b1;
                awready_r <= 1'b0;
                awaddr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && wready_r) begin
                w_hold_r <= 1'b1;
                wready_r <= 1'b0;
                wdat_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_hold_r <= 1'b0;
                w_hold_r <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r <= (awaddr_r == CVT_OFF_DIR_BASE || awaddr_r == CVT_OFF_CTRL ||
                    awaddr_r == CVT_OFF_STAT) ? CVT_RESP_OKAY : CVT_RESP_SLVERR;
            end
            if (bvalid_r && s_axi_bready) begin
                bvalid_r <= 1'b0;
                awready_r <= 1'b1;
                wready_r <= 1'b1;
            end
        end
    end

    // Software registers; the low bits of the base stay zero to keep it page aligned.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            base_r <= 20'h00000;
            ctrl_r <= CVT_CTRL_RST;
        end else if (wr_go) begin
            if (base_wr) begin
                base_r <= (base_r & ~wmask[31:12]) | (wdat_r[31:12] & wmask[31:12]);
            end
            if (awaddr_r == CVT_OFF_CTRL) begin
                ctrl_r <= (ctrl_r & ~wmask[7:0]) | (wdat_r[7:0] & wmask[7:0] & CVT_CTRL_MASK);
            end
        end
    end

    // Status flags: a fault set in the same cycle as a clear wins.
    always_comb begin
        stat_nxt = stat_r;
        if (wr_go && awaddr_r == CVT_OFF_STAT) begin
            stat_nxt = stat_r & ~(wdat_r[7:0] & wmask[7:0] & CVT_STAT_MASK);
        end
        if (st_r == CVT_ST_PDE_RD || st_r == CVT_ST_PTE_RD) begin
            if (mem_ack && np) begin
                stat_nxt[CVT_STAT_NP] = 1'b1; // R14 R25
            end else if (mem_ack && pv) begin
                stat_nxt[CVT_STAT_PV] = 1'b1; // R13 R25
            end
        end
    end

    // Interrupt outputs follow the flags only while enabled.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            stat_r <= 8'h00;
            np_irq_r <= 1'b0;
            pv_irq_r <= 1'b0;
        end else begin
            stat_r <= stat_nxt;
            np_irq_r <= stat_nxt[CVT_STAT_NP] && ctrl_r[CVT_CTRL_NP_EN]; // R25
            pv_irq_r <= stat_nxt[CVT_STAT_PV] && ctrl_r[CVT_CTRL_PV_EN]; // R25
        end
    end

    // Read channel; the base register is write-only and reads as zero.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            arready_r <= 1'b1;
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= CVT_RESP_OKAY;
        end else if (s_axi_arvalid && arready_r) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b1;
            rresp_r <= CVT_RESP_OKAY;
            unique case (s_axi_araddr)
                CVT_OFF_DIR_BASE: rdata_r <= 32'h0000_0000;
                CVT_OFF_CUR_VA: rdata_r <= {cva_r, 12'h000};
                CVT_OFF_CTRL: rdata_r <= {24'h000000, ctrl_r};
                CVT_OFF_STAT: rdata_r <= {24'h000000, stat_r};
                default: begin
                    rdata_r <= 32'h0000_0000;
                    rresp_r <= CVT_RESP_SLVERR;
                end
            endcase
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_r <= 1'b0;
            arready_r <= 1'b1;
        end
    end

    // Request decode: source maps never write, supervisor skips the rights checks but not the present check.
    assign accept = cp_valid && cp_ready_r;
    assign wr_eff = cp_write && cp_dst; // R22
    assign user = ctrl_r[CVT_CTRL_PRIV]; // R23
    assign hit = val_r[cp_dst] && tag_r[cp_dst] == cp_addr[31:CVT_TBL_LSB]; // R18
    assign np = !mem_rdata[CVT_ENT_P]; // R14
    assign pv = user && (!mem_rdata[CVT_ENT_US] || (wr_r && !mem_rdata[CVT_ENT_RW])); // R11 R12
    assign fill_frame = (st_r == CVT_ST_PTE_RD) ? mem_rdata[31:12] : ent_r[31:12];

    // Walk sequencing; write-backs change only the accessed and dirty bits.
    always_comb begin
        st_nxt = st_r;
        iss = 1'b0;
        iss_we = 1'b0;
        iss_addr = la_r;
        iss_wdata = cwd_r;
        fill = 1'b0;
        unique case (st_r)
            CVT_ST_IDLE: begin
                if (accept) begin
                    iss = 1'b1;
                    iss_wdata = cp_wdata;
                    st_nxt = CVT_ST_DATA;
                    if (!ctrl_r[CVT_CTRL_ON]) begin
                        iss_we = wr_eff;
                        iss_addr = cp_addr; // R1 R2 R24
                    end else if (hit) begin
                        iss_we = wr_eff;
                        iss_addr = {frame_r[cp_dst], cp_addr[CVT_TBL_LSB-1:0]}; // R18
                    end else begin
                        iss_addr = {base_r, cp_addr[31:CVT_DIR_LSB], 2'b00}; // R4 R19 R27
                        st_nxt = CVT_ST_PDE_RD; // R3
                    end
                end
            end
            CVT_ST_PDE_RD: begin
                if (mem_ack) begin
                    iss = !(np || pv);
                    if (np || pv) begin
                        st_nxt = CVT_ST_FAULT; // R13 R14
                    end else if (!mem_rdata[CVT_ENT_A]) begin
                        iss_we = 1'b1;
                        iss_addr = mem_addr_r;
                        iss_wdata = mem_rdata | (32'h1 << CVT_ENT_A); // R9 R15
                        st_nxt = CVT_ST_PDE_WB;
                    end else begin
                        iss_addr = {mem_rdata[31:12], la_r[21:CVT_TBL_LSB], 2'b00}; // R6 R27
                        st_nxt = CVT_ST_PTE_RD;
                    end
                end
            end
            CVT_ST_PDE_WB: begin
                if (mem_ack) begin
                    iss = 1'b1;
                    iss_addr = {ent_r[31:12], la_r[21:CVT_TBL_LSB], 2'b00}; // R6 R27
                    st_nxt = CVT_ST_PTE_RD;
                end
            end
            CVT_ST_PTE_RD: begin
                if (mem_ack) begin
                    iss = !(np || pv);
                    if (np || pv) begin
                        st_nxt = CVT_ST_FAULT; // R13 R14
                    end else if (!mem_rdata[CVT_ENT_A] || (wr_r && !mem_rdata[CVT_ENT_D])) begin
                        iss_we = 1'b1;
                        iss_addr = mem_addr_r;
                        iss_wdata = mem_rdata | (32'h1 << CVT_ENT_A) |
                            ({31'h0, wr_r} << CVT_ENT_D); // R9 R10 R15
                        st_nxt = CVT_ST_PTE_WB;
                    end else begin
                        fill = 1'b1;
                        iss_we = wr_r;
                        iss_addr = {mem_rdata[31:12], la_r[CVT_TBL_LSB-1:0]}; // R7 R8
                        st_nxt = CVT_ST_DATA;
                    end
                end
            end
            CVT_ST_PTE_WB: begin
                if (mem_ack) begin
                    iss = 1'b1;
                    fill = 1'b1;
                    iss_we = wr_r;
                    iss_addr = {ent_r[31:12], la_r[CVT_TBL_LSB-1:0]}; // R7
                    st_nxt = CVT_ST_DATA;
                end
            end
            CVT_ST_DATA: begin
                if (mem_ack) begin
                    st_nxt = CVT_ST_IDLE;
                end
            end
            CVT_ST_FAULT: begin
                if (!stat_r[CVT_STAT_NP] && !stat_r[CVT_STAT_PV]) begin
                    iss = 1'b1;
                    iss_addr = {base_r, la_r[31:CVT_DIR_LSB], 2'b00}; // R26
                    st_nxt = CVT_ST_PDE_RD;
                end
            end
        endcase
    end

    // Walk state, latched request and answer to the coprocessor.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            st_r <= CVT_ST_IDLE;
            la_r <= 32'h0000_0000;
            cwd_r <= 32'h0000_0000;
            wr_r <= 1'b0;
            map_r <= 1'b0;
            ent_r <= 32'h0000_0000;
            cva_r <= 20'h00000;
            cp_ready_r <= 1'b1;
            cp_done_r <= 1'b0;
            cp_rdata_r <= 32'h0000_0000;
        end else begin
            st_r <= st_nxt;
            cp_ready_r <= st_nxt == CVT_ST_IDLE;
            cp_done_r <= st_r == CVT_ST_DATA && mem_ack;
            if (accept) begin
                la_r <= cp_addr;
                cwd_r <= cp_wdata;
                wr_r <= wr_eff;
                map_r <= cp_dst;
            end
            if (mem_ack) begin
                ent_r <= mem_rdata;
            end
            if (st_r == CVT_ST_DATA && mem_ack) begin
                cp_rdata_r <= mem_rdata;
            end
            if (st_nxt == CVT_ST_FAULT && st_r != CVT_ST_FAULT) begin
                cva_r <= la_r[31:12];
            end
        end
    end

    // Memory port: request stands until its acknowledge.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            mem_req_r <= 1'b0;
            mem_we_r <= 1'b0;
            mem_addr_r <= 32'h0000_0000;
            mem_wdata_r <= 32'h0000_0000;
        end else if (iss) begin
            mem_req_r <= 1'b1;
            mem_we_r <= iss_we;
            mem_addr_r <= iss_addr;
            mem_wdata_r <= iss_wdata;
        end else if (mem_ack) begin
            mem_req_r <= 1'b0;
        end
    end

    // Look-aside entries; a flush beats a fill since the old walk may be stale.
    genvar gi;
    generate
        for (gi = 0; gi < CVT_TLB_N; gi++) begin : g_tlb
            always_ff @(posedge clock or negedge nrst) begin
                if (!nrst) begin
                    val_r[gi] <= 1'b0;
                    tag_r[gi] <= 20'h00000;
                    frame_r[gi] <= 20'h00000;
                end else if (flush) begin
                    val_r[gi] <= 1'b0; // R20 R21
                end else if (fill && map_r == 1'(gi)) begin
                    val_r[gi] <= 1'b1; // R16 R17 R19
                    tag_r[gi] <= la_r[31:12];
                    frame_r[gi] <= fill_frame;
                end
            end
        end
    endgenerate

    assign s_axi_awready = awready_r;
    assign s_axi_wready = wready_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;
    assign cp_ready = cp_ready_r;
    assign cp_done = cp_done_r;
    assign cp_rdata = cp_rdata_r;
    assign mem_req = mem_req_r;
    assign mem_we = mem_we_r;
    assign mem_addr = mem_addr_r;
    assign mem_wdata = mem_wdata_r;
    assign missing_page_irq = np_irq_r;
    assign rights_fault_irq = pv_irq_r;

    // Checks on the walk; all share the one clock and reset.
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!nrst);

    a_off_passthru: assert property (st_r == CVT_ST_IDLE && accept && !ctrl_r[CVT_CTRL_ON]
        |=> mem_req_r && mem_addr_r == $past(cp_addr)) // R1
        else $error("untranslated address changed");
    a_hit_address: assert property (st_r == CVT_ST_IDLE && accept && ctrl_r[CVT_CTRL_ON] && hit
        |=> mem_addr_r[11:0] == $past(cp_addr[11:0]) && st_r == CVT_ST_DATA) // R18
        else $error("hit address wrong");
    a_dir_fetch: assert property ($rose(mem_req_r) && st_r == CVT_ST_PDE_RD
        |-> mem_addr_r == {base_r, la_r[31:22], 2'b00} && !mem_we_r) // R27
        else $error("directory fetch address wrong");
    a_accessed_set: assert property (mem_req_r && mem_we_r &&
        (st_r == CVT_ST_PDE_WB || st_r == CVT_ST_PTE_WB) |-> mem_wdata_r[CVT_ENT_A]) // R9
        else $error("write-back lacks accessed flag");
    a_dirty_set: assert property (mem_req_r && st_r == CVT_ST_PTE_WB && wr_r
        |-> mem_wdata_r[CVT_ENT_D] && mem_wdata_r[31:7] == ent_r[31:7]) // R10
        else $error("dirty write-back wrong");
    a_missing_flag: assert property (st_r == CVT_ST_PTE_RD && mem_ack && np
        |=> stat_r[CVT_STAT_NP] && st_r == CVT_ST_FAULT && !mem_req_r) // R14
        else $error("missing page not flagged");
    a_user_denied: assert property (st_r inside {CVT_ST_PDE_RD, CVT_ST_PTE_RD} && mem_ack &&
        !np && user && !mem_rdata[CVT_ENT_US] |=> stat_r[CVT_STAT_PV] ##1 !mem_req_r) // R12
        else $error("user access not refused");
    a_irq_gate: assert property (missing_page_irq |-> $past(ctrl_r[CVT_CTRL_NP_EN])) // R25
        else $error("interrupt raised while disabled");
    a_base_flush: assert property (base_wr |=> val_r == '0) // R20
        else $error("base write kept entries");
    a_suspend_flush: assert property (suspend |=> val_r == '0) // R21
        else $error("suspend kept entries");
    a_src_no_write: assert property (st_r == CVT_ST_DATA && mem_we_r |-> map_r) // R22
        else $error("source map write");
    a_retry_walk: assert property (st_r == CVT_ST_FAULT && stat_r[7:6] == 2'b00
        |=> st_r == CVT_ST_PDE_RD && mem_req_r) // R26
        else $error("cleared fault not retried");

    c_tlb_hit: cover property (st_r == CVT_ST_IDLE && accept && ctrl_r[CVT_CTRL_ON] && hit);
    c_dirty_walk: cover property (st_r == CVT_ST_PTE_WB && wr_r && mem_ack);
    c_fault_retry: cover property (st_r == CVT_ST_FAULT ##1 st_r == CVT_ST_PDE_RD);
    c_suspend: cover property (suspend && val_r != '0);
endmodule : cvt_translate

// File: tb/cvt_mem_model.sv
// Behavioural system memory that answers the translation unit's requests.
`timescale 1ns/1ps
module cvt_mem_model (
    input wire logic clock,
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [31:0] mem_addr,
    input wire logic [31:0] mem_wdata,
    input wire logic slow,
    output logic mem_ack,
    output logic [31:0] mem_rdata
);
    logic [31:0] m [logic [31:0]];
    logic [1:0] wait_r = 2'h0;
    initial mem_ack = 1'b0;
    initial mem_rdata = 32'h0;
    // Idle data toggles every cycle, so a read taken off the ack edge shows up.
    always @(posedge clock) begin
        mem_ack <= 1'b0;
        mem_rdata <= ~mem_rdata;
        if (mem_req && !mem_ack && wait_r != 2'h0) begin
            wait_r <= wait_r - 2'h1;
        end else if (mem_req && !mem_ack) begin
            mem_ack <= 1'b1;
            wait_r <= slow ? 2'h3 : 2'h0;
            mem_rdata <= m.exists(mem_addr) ? m[mem_addr] : 32'h0;
            if (mem_we) m[mem_addr] = mem_wdata;
        end
    end
endmodule : cvt_mem_model

// File: tb/tb_top.sv
// Self-checking bench for the coprocessor address translation unit.
`timescale 1ns/1ps
module tb_top;
    import cvt_pkg::*;
    logic clock, nrst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, suspend;
    logic cp_valid, cp_ready, cp_write, cp_dst, cp_done, mem_req, mem_we, mem_ack, slow, ok;
    logic missing_page_irq, rights_fault_irq;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic [31:0] s_axi_wdata, s_axi_rdata, cp_addr, cp_wdata, cp_rdata, mem_addr, mem_wdata;
    logic [31:0] mem_rdata, seed, la, d, e, g, pte;
    int fail_count, n_tests, cyc;
    localparam logic [31:0] BASE = 32'h0001_0000;
    localparam logic [31:0] PTB = 32'h0002_0000;
    localparam logic [31:0] F1 = 32'h0003_0000;
    localparam logic [31:0] F2 = 32'h0004_0000;
    cvt_translate dut (.clock, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .suspend, .cp_valid, .cp_ready, .cp_addr, .cp_write, .cp_dst, .cp_wdata,
        .cp_done, .cp_rdata, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata,
        .missing_page_irq, .rights_fault_irq);
    cvt_mem_model mem (.clock, .mem_req, .mem_we, .mem_addr, .mem_wdata, .slow, .mem_ack,
        .mem_rdata);
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    // The run needs under two thousand cycles; a hang is cut off.
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            fail_count++;
            print_verdict();
        end
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs
    // Word address of an entry: table base page plus four times the index.
    function automatic logic [31:0] ent(input logic [31:0] b, input logic [9:0] i);
        return {b[31:12], i, 2'h0};
    endfunction : ent
    function automatic logic [31:0] phys(input logic [31:0] f, input logic [31:0] a);
        return {f[31:12], a[11:0]};
    endfunction : phys
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic print_verdict();
        $display("Counts: %0d compares, %0d mismatches", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : print_verdict
    // Each bus task starts one edge on, so no strobe is lowered and raised in one step.
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clock);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do begin
            @(posedge clock);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : axi_wr
    task automatic axi_rd(input logic [7:0] a);
        @(posedge clock);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do begin
            @(posedge clock);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        g = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : axi_rd
    task automatic cp_go(input logic [31:0] a, input logic w, input logic dst, input logic [31:0] v);
        @(posedge clock);
        {cp_addr, cp_write, cp_dst, cp_wdata, cp_valid} <= {a, w, dst, v, 1'b1};
        do @(posedge clock); while (cp_ready !== 1'b1);
        cp_valid <= 1'b0;
    endtask : cp_go
    task automatic cp_end(input int n);
        ok = 1'b0;
        for (int i = 0; i < n && !ok; i++) begin
            @(posedge clock);
            ok = (cp_done === 1'b1);
            g = cp_rdata;
        end
    endtask : cp_end
    task automatic cp_do(input logic [31:0] a, input logic w, input logic dst, input logic [31:0] v);
        cp_go(a, w, dst, v);
        cp_end(80);
        chk(32'(ok), 32'h1);
    endtask : cp_do
    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
        {suspend, cp_valid, cp_write, cp_dst, slow, nrst} = 6'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, cp_addr, cp_wdata} = '0;
        s_axi_wstrb = 4'hF;
        {fail_count, n_tests, cyc} = '0;
        seed = xs(32'h65d05e3a);
        repeat (6) @(posedge clock);
        nrst <= 1'b1;
        // Translation off: the linear address reaches memory untouched.
        la = seed & 32'h00FF_FFFC;
        d = xs(seed);
        mem.m[la] = d;
        cp_do(la, 1'b0, 1'b0, 32'h0);
        chk(g, d);
        axi_rd(8'h10);
        chk(32'(rs), 32'(CVT_RESP_SLVERR));
        axi_rd(CVT_OFF_CTRL);
        chk(g, 32'(CVT_CTRL_RST));
        $display("test direct done");
        // Walk with loose bit 9 set; a source-map write must behave as a read.
        seed = xs(d);
        la = seed & 32'hFFFF_CFFC;
        pte = ent(PTB, la[21:12]);
        mem.m[ent(BASE, la[31:22])] = PTB | 32'h207;
        mem.m[pte] = F1 | 32'h207;
        d = xs(seed);
        mem.m[phys(F1, la)] = d;
        axi_wr(CVT_OFF_DIR_BASE, BASE);
        axi_wr(CVT_OFF_CTRL, 32'hC1);
        chk(32'(rs), 32'(CVT_RESP_OKAY));
        slow = 1'b1;
        cp_do(la, 1'b1, 1'b0, ~d);
        chk(g, d);
        chk(mem.m[ent(BASE, la[31:22])], PTB | 32'h227);
        chk(mem.m[pte], F1 | 32'h227);
        d = xs(d);
        cp_do(la, 1'b1, 1'b1, d);
        chk(mem.m[phys(F1, la)], d);
        chk(mem.m[pte], F1 | 32'h267);
        $display("test walk done");
        // Hits keep the stored frame until suspend or a base write flushes them.
        e = xs(d);
        mem.m[pte] = F2 | 32'h267;
        mem.m[phys(F2, la)] = e;
        cp_do(la, 1'b0, 1'b0, 32'h0);
        chk(g, d);
        @(posedge clock);
        suspend <= 1'b1;
        @(posedge clock);
        suspend <= 1'b0;
        cp_do(la, 1'b0, 1'b0, 32'h0);
        chk(g, e);
        mem.m[pte] = F1 | 32'h267;
        axi_wr(CVT_OFF_DIR_BASE, BASE);
        cp_do(la, 1'b0, 1'b0, 32'h0);
        chk(g, d);
        $display("test flush done");
        // Missing table entry stalls the access until its flag is cleared.
        la = la ^ 32'h0000_1000;
        pte = ent(PTB, la[21:12]);
        mem.m[pte] = F2 | 32'h206;
        cp_go(la, 1'b0, 1'b0, 32'h0);
        cp_end(40);
        chk(32'(ok), 32'h0);
        axi_rd(CVT_OFF_STAT);
        chk(g, 32'h80);
        chk(32'(missing_page_irq), 32'h1);
        axi_rd(CVT_OFF_CUR_VA);
        chk(g, {la[31:12], 12'h0});
        mem.m[pte] = F2 | 32'h207;
        axi_wr(CVT_OFF_STAT, 32'h80);
        cp_end(80);
        chk(32'(ok), 32'h1);
        chk(g, e);
        $display("test missing done");
        // Supervisor ignores the user flag; user mode then refuses the write.
        la = la ^ 32'h0000_2000;
        pte = ent(PTB, la[21:12]);
        mem.m[pte] = F1 | 32'h201;
        cp_do(la, 1'b0, 1'b0, 32'h0);
        chk(g, d);
        axi_wr(CVT_OFF_CTRL, 32'hC5);
        cp_go(la, 1'b1, 1'b1, e);
        cp_end(40);
        chk(32'(ok), 32'h0);
        axi_rd(CVT_OFF_STAT);
        chk({g[30:0], rights_fault_irq}, 32'h81);
        mem.m[pte] = F1 | 32'h227;
        axi_wr(CVT_OFF_STAT, 32'h40);
        cp_end(80);
        chk(32'(ok), 32'h1);
        chk(mem.m[phys(F1, la)], e);
        $display("test rights done");
        print_verdict();
    end
endmodule : tb_top
